// file: shpa_buf.sv
// small write buffer in flip-flops, valid/ready on both sides
`timescale 1ns/1ns
module shpa_buf #(
  parameter int DEPTH = 2,
  parameter int AW = 16,
  parameter int DW = 8
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  shpa_wr_if.snk in_port,
  output logic out_valid_o,
  output logic [AW-1:0] out_addr_o,
  output logic [DW-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  logic [AW+DW-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [PW:0] count;
  logic push, pop;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_next

  assign in_port.ready = (count != FULL_CNT);
  assign push = in_port.valid && in_port.ready;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= {in_port.addr, in_port.data};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= ptr_next(wr_ptr);
      if (pop) rd_ptr <= ptr_next(rd_ptr);
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // output word held in flops, refreshed from the head after each pop
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      out_valid_o <= 1'b0;
      out_addr_o <= '0;
      out_data_o <= '0;
    end else begin
      out_valid_o <= (count - (PW+1)'(pop) + (PW+1)'(push)) != '0;
      if (count - (PW+1)'(pop) != '0) begin
        {out_addr_o, out_data_o} <= mem[pop ? ptr_next(rd_ptr) : rd_ptr];
      end else if (push) begin
        {out_addr_o, out_data_o} <= {in_port.addr, in_port.data};
      end
    end
  end
endmodule : shpa_buf

// file: shpa_ee_model.sv
// external eeprom answering the autoconfig read
`timescale 1ns/1ns
module shpa_ee_model (
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic [23:0] hdr_o
);
  int cnt = 0;
  logic [7:0] cur;
  initial begin
    miso_o = 1'b1;
    hdr_o = 24'h000000;
  end
  always @(negedge cs_n_i) cnt = 0;
  always @(posedge sclk_i) if (!cs_n_i) begin
    if (cnt < 24) hdr_o <= {hdr_o[22:0], mosi_i};
    cnt <= cnt + 1;
  end
  // released line toggles so a stale bit never looks valid
  always @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) miso_o <= ~miso_o;
    else if (cnt >= 24) begin
      cur = (hdr_o[7:0] + 8'((cnt - 24) / 8)) ^ 8'hC3;
      miso_o <= cur[7 - (cnt - 24) % 8];
    end
  end
endmodule : shpa_ee_model

// file: shpa_pkg.sv
// constants shared by the serial host port and autoconfig reader
package shpa_pkg;
  localparam int CLK_NS = 10;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam int PAGE_AW = 5;
  localparam int PAGE_BYTES = 32;
  localparam logic [PAGE_AW-1:0] PAGE_LAST = 5'h1F;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES = (PROG_TIME_MS * 1000000) / CLK_NS;
  localparam int PROG_TW = 20;
  localparam int MST_HALF_NS = 80;
  localparam int MST_HALF_CYC = (MST_HALF_NS / CLK_NS) < 1 ? 1 : (MST_HALF_NS / CLK_NS);
  localparam int HDR_BITS = 24;
  localparam logic [1:0] PH_CMD = 2'h0;
  localparam logic [1:0] PH_AHI = 2'h1;
  localparam logic [1:0] PH_ALO = 2'h2;
  localparam logic [1:0] PH_DATA = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 3;
  localparam int PIN_TSEL = 4;
  localparam int PIN_N = 5;
  typedef enum logic [1:0] {P_IDLE, P_WRITE, P_WAIT} shpa_prog_t;
  typedef enum logic [1:0] {M_IDLE, M_RUN, M_DONE} shpa_mst_t;
endpackage : shpa_pkg

// file: shpa_sync.sv
// three-stage pin synchroniser with debounced level and edge pulses
`timescale 1ns/1ns
module shpa_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1, s2, s3;
      always_ff @(posedge mclk_i) begin
        s1 <= pin_i[g];
        s2 <= s1;
        s3 <= s2;
      end
      // a change only counts once stages two and three agree
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          lvl_o[g] <= 1'b1;
          rise_o[g] <= 1'b0;
          fall_o[g] <= 1'b0;
        end else begin
          rise_o[g] <= (s2 == s3) && s3 && !lvl_o[g];
          fall_o[g] <= (s2 == s3) && !s3 && lvl_o[g];
          if (s2 == s3) begin
            lvl_o[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule : shpa_sync

// file: shpa_top.sv
// serial host port: register/eeprom slave and autoconfig eeprom reader
`timescale 1ns/1ns
module shpa_top import shpa_pkg::*; #(
  parameter bit HAS_EEPROM = 1'b1,
  parameter int PROG_CYC = PROG_CYCLES,
  parameter int AC_BYTES = 16,
  parameter logic [15:0] AC_ROM_ADDR = 16'h0000,
  parameter logic [15:0] AC_REG_BASE = 16'h0000,
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic master_strap_i,
  input wire logic memory_target_select_i,
  input wire logic chip_select_low_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic chip_select_low_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic mst_pins_oe_o,
  output logic autoconfig_done_o,
  output logic [15:0] rd_addr_o,
  output logic rd_en_o,
  input wire logic [7:0] rd_data_i,
  output logic [15:0] ee_addr_o,
  output logic ee_rd_o,
  input wire logic [7:0] ee_rdata_i,
  output logic ee_wr_o,
  output logic [7:0] ee_wdata_o,
  output logic wr_valid_o,
  output logic [15:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  input wire logic wr_ready_i
);
  localparam int MBW = 16;
  localparam logic [MBW-1:0] MST_TOTAL = MBW'(HDR_BITS + BYTE_W * AC_BYTES);
  localparam logic [MBW-1:0] MST_HDR = MBW'(HDR_BITS);
  localparam logic [3:0] HALF_LAST = 4'(MST_HALF_CYC - 1);
  localparam logic [PROG_TW-1:0] PROG_LAST = PROG_TW'(PROG_CYC - 1);
  localparam logic [PAGE_AW:0] PAGE_CNT = (PAGE_AW+1)'(PAGE_BYTES);

  shpa_wr_if wr_q();
  logic [PIN_N-1:0] pin_lvl, pin_rise, pin_fall;
  logic master_mode;
  logic cs_hi, cs_rise, sclk_rise, sclk_fall, byte_done, ee_sel;
  logic [6:0] rx_sh;
  logic [7:0] rx_byte, cmd, tx_sh;
  logic [2:0] bit_cnt;
  logic [1:0] phase;
  logic [15:0] addr;
  logic fetch_req, ee_fetch, load_reg, load_ee, load_idle, wel, ee_wtx, ee_dirty;
  logic slv_push, mst_push;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [15:PAGE_AW] page_sel;
  logic copy_on, copy_rd, copy_cap;
  logic [PAGE_AW:0] copy_idx;
  logic [PAGE_AW-1:0] copy_rd_idx, copy_cap_idx;
  shpa_prog_t prog_st;
  logic prog_start, prog_busy;
  logic [PAGE_AW:0] prog_idx;
  logic [PROG_TW-1:0] prog_tmr;
  shpa_mst_t mst_st;
  logic [3:0] div_cnt;
  logic tick;
  logic [23:0] mst_tx;
  logic [7:0] mst_rx;
  logic [MBW-1:0] mst_bits;
  logic [15:0] mst_waddr;

  // page wrap only for eeprom writes, linear otherwise
  function automatic logic [15:0] next_address(input logic [15:0] a, input logic wrap);
    if (wrap) begin
      next_address = {a[15:PAGE_AW], PAGE_AW'(a[PAGE_AW-1:0] + 1'b1)};
    end else begin
      next_address = 16'(a + 1'b1);
    end
  endfunction : next_address

  shpa_sync #(.W(PIN_N)) u_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .pin_i({memory_target_select_i, miso_i, mosi_i, sclk_i, chip_select_low_i}),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  shpa_buf #(.DEPTH(BUF_DEPTH), .AW(ADDR_W), .DW(BYTE_W)) u_buf (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .in_port(wr_q.snk),
    .out_valid_o(wr_valid_o),
    .out_addr_o(wr_addr_o),
    .out_data_o(wr_data_o),
    .out_ready_i(wr_ready_i)
  );

  // strap caught on the clock while reset is held
  always_ff @(posedge mclk_i) begin
    if (srst_i) master_mode <= master_strap_i;
  end

  assign cs_hi = pin_lvl[PIN_CS] || master_mode;
  assign cs_rise = pin_rise[PIN_CS] && !master_mode;
  assign sclk_rise = pin_rise[PIN_SCLK] && !cs_hi;
  assign sclk_fall = pin_fall[PIN_SCLK] && !cs_hi;
  assign rx_byte = {rx_sh, pin_lvl[PIN_MOSI]};
  assign byte_done = sclk_rise && (bit_cnt == BIT_LAST);
  assign ee_sel = HAS_EEPROM && pin_lvl[PIN_TSEL];
  assign prog_busy = (prog_st != P_IDLE);

  // serial receive framing; deselect returns to the command phase
  always_ff @(posedge mclk_i) begin
    if (srst_i || cs_hi) begin
      bit_cnt <= '0;
      phase <= PH_CMD;
    end else if (sclk_rise) begin
      rx_sh <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 1'b1;
      if (bit_cnt == BIT_LAST && phase != PH_DATA) phase <= phase + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cmd <= '0;
    end else if (byte_done && phase == PH_CMD) begin
      cmd <= rx_byte;
    end
  end

  // a write byte is stored only once its last bit is sampled
  assign slv_push = byte_done && phase == PH_DATA && cmd == CMD_WRITE && !ee_sel;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      addr <= '0;
    end else if (byte_done && phase == PH_AHI) begin
      addr[15:8] <= rx_byte;
    end else if (byte_done && phase == PH_ALO) begin
      addr[7:0] <= rx_byte;
    end else if (slv_push || (byte_done && phase == PH_DATA && cmd == CMD_WRITE && ee_wtx)) begin
      addr <= next_address(addr, ee_sel);
    end else if (fetch_req) begin
      addr <= next_address(addr, 1'b0);
    end
  end

  // read prefetch: fetch after the low address byte and each data byte, load shifter before next fall
  always_ff @(posedge mclk_i) begin
    if (srst_i || cs_hi) begin
      fetch_req <= 1'b0;
    end else begin
      fetch_req <= byte_done && cmd == CMD_READ && (phase == PH_ALO || phase == PH_DATA);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_en_o <= 1'b0;
      rd_addr_o <= '0;
      load_reg <= 1'b0;
      ee_fetch <= 1'b0;
      load_ee <= 1'b0;
      load_idle <= 1'b0;
    end else begin
      rd_en_o <= fetch_req && !ee_sel;
      if (fetch_req) rd_addr_o <= addr;
      load_reg <= rd_en_o;
      // eeprom data stands only the cycle after its read strobe
      ee_fetch <= fetch_req && ee_sel && !prog_busy;
      load_ee <= ee_fetch;
      load_idle <= fetch_req && ee_sel && prog_busy;
    end
  end

  // transmit shifter and pin, MSB first, updated on falling SCLK
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_sh <= '0;
    end else if (byte_done && (phase == PH_CMD ? rx_byte == CMD_RDSR : cmd == CMD_RDSR)) begin
      tx_sh <= '0;
      tx_sh[STATUS_BUSY_BIT] <= prog_busy;
    end else if (load_reg) begin
      tx_sh <= rd_data_i;
    end else if (load_ee) begin
      tx_sh <= ee_rdata_i;
    end else if (load_idle) begin
      tx_sh <= IDLE_BYTE;
    end else if (sclk_fall && miso_oe_o) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || cs_hi) begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      if (sclk_fall && miso_oe_o) miso_o <= tx_sh[7];
      if (byte_done && ((phase == PH_CMD && rx_byte == CMD_RDSR) || (phase == PH_ALO && cmd == CMD_READ))) begin
        miso_oe_o <= 1'b1;
      end
    end
  end

  // write-enable latch and eeprom write transaction tracking
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wel <= 1'b0;
      ee_wtx <= 1'b0;
      ee_dirty <= 1'b0;
      prog_start <= 1'b0;
    end else begin
      prog_start <= 1'b0;
      if (cs_rise && phase == PH_AHI && bit_cnt == '0 && cmd == CMD_WREN) begin
        wel <= 1'b1;
      end
      if (byte_done && phase == PH_ALO && cmd == CMD_WRITE && ee_sel && wel && !prog_busy) begin
        ee_wtx <= 1'b1;
      end
      if (byte_done && phase == PH_DATA && ee_wtx) ee_dirty <= 1'b1;
      if (cs_rise && ee_wtx) begin
        prog_start <= ee_dirty && bit_cnt == '0;
        wel <= 1'b0;
        ee_wtx <= 1'b0;
        ee_dirty <= 1'b0;
      end
    end
  end

  // page copy on address completion, then received bytes overlay it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      copy_on <= 1'b0;
      copy_idx <= '0;
      copy_rd <= 1'b0;
      copy_rd_idx <= '0;
      copy_cap <= 1'b0;
      copy_cap_idx <= '0;
      page_sel <= '0;
    end else begin
      // capture two cycles after the request: strobe, then data
      copy_rd <= copy_on;
      copy_rd_idx <= copy_idx[PAGE_AW-1:0];
      copy_cap <= copy_rd;
      copy_cap_idx <= copy_rd_idx;
      if (byte_done && phase == PH_ALO && cmd == CMD_WRITE && ee_sel && wel && !prog_busy) begin
        copy_on <= 1'b1;
        copy_idx <= '0;
        page_sel <= {addr[15:8], rx_byte[7:PAGE_AW]};
      end else if (copy_on) begin
        copy_idx <= copy_idx + 1'b1;
        if (copy_idx[PAGE_AW-1:0] == PAGE_LAST) copy_on <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (copy_cap) begin
      page_buf[copy_cap_idx] <= ee_rdata_i;
    end else if (byte_done && phase == PH_DATA && ee_wtx) begin
      page_buf[addr[PAGE_AW-1:0]] <= rx_byte;
    end
  end

  // page programming then hold-off while the array is busy
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prog_st <= P_IDLE;
      prog_idx <= '0;
      prog_tmr <= '0;
    end else begin
      case (prog_st)
        P_IDLE: begin
          prog_idx <= '0;
          prog_tmr <= '0;
          if (prog_start) prog_st <= P_WRITE;
        end
        P_WRITE: begin
          prog_idx <= prog_idx + 1'b1;
          if (prog_idx == PAGE_CNT - 1'b1) prog_st <= P_WAIT;
        end
        P_WAIT: begin
          prog_tmr <= prog_tmr + 1'b1;
          if (prog_tmr == PROG_LAST) prog_st <= P_IDLE;
        end
        default: prog_st <= P_IDLE;
      endcase
    end
  end

  // eeprom port: programming, page copy and slave fetch never overlap
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ee_addr_o <= '0;
      ee_rd_o <= 1'b0;
      ee_wr_o <= 1'b0;
      ee_wdata_o <= '0;
    end else begin
      ee_rd_o <= 1'b0;
      ee_wr_o <= 1'b0;
      if (prog_st == P_WRITE) begin
        ee_wr_o <= 1'b1;
        ee_addr_o <= {page_sel, prog_idx[PAGE_AW-1:0]};
        ee_wdata_o <= page_buf[prog_idx[PAGE_AW-1:0]];
      end else if (copy_on) begin
        ee_rd_o <= 1'b1;
        ee_addr_o <= {page_sel, copy_idx[PAGE_AW-1:0]};
      end else if (fetch_req && ee_sel && !prog_busy) begin
        ee_rd_o <= 1'b1;
        ee_addr_o <= addr;
      end
    end
  end

  // autoconfig master; the whole link stalls while the buffer is full
  always_ff @(posedge mclk_i) begin
    if (srst_i || mst_st != M_RUN || !wr_q.ready) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == HALF_LAST);
      div_cnt <= (div_cnt == HALF_LAST) ? '0 : div_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mst_st <= M_IDLE;
      chip_select_low_o <= 1'b1;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      mst_tx <= '0;
      mst_rx <= '0;
      mst_bits <= '0;
      mst_push <= 1'b0;
    end else begin
      mst_push <= 1'b0;
      case (mst_st)
        M_IDLE: begin
          if (master_mode) begin
            mst_st <= M_RUN;
            chip_select_low_o <= 1'b0;
            mst_tx <= {CMD_READ, AC_ROM_ADDR};
            mosi_o <= CMD_READ[7];
          end
        end
        M_RUN: begin
          if (tick && wr_q.ready && !sclk_o) begin
            sclk_o <= 1'b1;
            mst_rx <= {mst_rx[6:0], pin_lvl[PIN_MISO]};
            mst_bits <= mst_bits + 1'b1;
            mst_push <= (mst_bits >= MST_HDR) && (mst_bits[2:0] == BIT_LAST);
          end else if (tick && wr_q.ready) begin
            sclk_o <= 1'b0;
            mst_tx <= {mst_tx[22:0], 1'b0};
            mosi_o <= mst_tx[22];
            if (mst_bits == MST_TOTAL) begin
              chip_select_low_o <= 1'b1;
              mst_st <= M_DONE;
            end
          end
        end
        M_DONE: mst_st <= M_DONE;
        default: mst_st <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mst_waddr <= AC_REG_BASE;
      mst_pins_oe_o <= 1'b0;
      autoconfig_done_o <= 1'b0;
    end else begin
      if (mst_push) mst_waddr <= 16'(mst_waddr + 1'b1);
      mst_pins_oe_o <= master_mode;
      autoconfig_done_o <= (mst_st == M_DONE);
    end
  end

  assign wr_q.valid = slv_push || mst_push;
  assign wr_q.addr = master_mode ? mst_waddr : addr;
  assign wr_q.data = master_mode ? mst_rx : rx_byte;

  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_miso_fall_only: assert property (miso_oe_o && $past(miso_oe_o) && !$past(sclk_fall) |-> $stable(miso_o))
    else $error("miso changed without a falling sclk");
  a_miso_release: assert property (cs_hi |=> !miso_oe_o)
    else $error("miso driven while deselected");
  a_deselect_reset: assert property (cs_hi |=> bit_cnt == '0 && phase == PH_CMD)
    else $error("serial state kept across deselect");
  a_write_whole_byte: assert property (slv_push |-> $past(bit_cnt) == BIT_LAST && $past(phase) == PH_DATA)
    else $error("register write from partial byte");
  a_page_wrap: assert property (byte_done && phase == PH_DATA && ee_wtx |=> addr[15:PAGE_AW] == $past(addr[15:PAGE_AW]))
    else $error("eeprom write left its page");
  a_wren_latch: assert property (cs_rise && phase == PH_AHI && bit_cnt == '0 && cmd == CMD_WREN |=> wel)
    else $error("write enable latch not set");
  a_abort_no_prog: assert property (cs_rise && ee_wtx && bit_cnt != '0 |=> !prog_start ##1 prog_st == P_IDLE)
    else $error("aborted eeprom write programmed");
  a_status_bit: assert property (byte_done && phase == PH_CMD && rx_byte == CMD_RDSR |=> tx_sh[STATUS_BUSY_BIT] == $past(prog_busy))
    else $error("status byte busy bit wrong");
  a_prog_page: assert property (prog_start |=> prog_st == P_WRITE ##PAGE_BYTES prog_st == P_WAIT)
    else $error("page program length wrong");
  a_mst_first_bit: assert property ($fell(chip_select_low_o) |-> mosi_o == CMD_READ[7] && !sclk_o)
    else $error("master header start wrong");
  a_mst_mosi_fall: assert property ($changed(mosi_o) && !$fell(chip_select_low_o) |-> $past(sclk_o) && !sclk_o)
    else $error("master mosi changed off a falling edge");
  a_mst_end: assert property ($rose(chip_select_low_o) |-> !sclk_o && mst_bits == MST_TOTAL)
    else $error("master read ended early or with sclk high");
endmodule : shpa_top

// file: shpa_wr_if.sv
// register write stream between the port logic and its buffer
`timescale 1ns/1ns
interface shpa_wr_if;
  logic valid;
  logic ready;
  logic [15:0] addr;
  logic [7:0] data;
  modport src(output valid, output addr, output data, input ready);
  modport snk(input valid, input addr, input data, output ready);
endinterface : shpa_wr_if

// file: tb_shpa_top.sv
// self-checking bench for the serial host port
`timescale 1ns/1ns
module tb_shpa_top;
  localparam int PC = 1000;
  logic mclk = 0, srst = 1, strap = 0, mts = 0, cs = 1, sclk = 0, mosi = 0, wr_ready = 1;
  logic [7:0] rd_data = 0, ee_rdata = 0, r = 0, ee_wdata, wr_data;
  logic [7:0] ee_mem [256];
  logic miso, miso_oe, cs_o, sclk_o, mosi_o, done, ee_rd, ee_wr, wr_valid, em_miso, rd_en, pins_oe;
  logic [15:0] rd_addr, ee_addr, wr_addr;
  logic [23:0] em_hdr;
  logic [23:0] wq [$];
  int errors = 0, cmp_count = 0, n_rd = 0, n_wr = 0;
  always #5 mclk = ~mclk;
  shpa_top #(.PROG_CYC(PC), .AC_BYTES(2)) u_dut (.mclk_i(mclk), .srst_i(srst), .master_strap_i(strap),
    .memory_target_select_i(mts), .chip_select_low_i(cs), .sclk_i(sclk), .mosi_i(mosi), .miso_i(em_miso),
    .miso_o(miso), .miso_oe_o(miso_oe), .chip_select_low_o(cs_o), .sclk_o(sclk_o), .mosi_o(mosi_o),
    .mst_pins_oe_o(pins_oe), .autoconfig_done_o(done), .rd_addr_o(rd_addr), .rd_en_o(rd_en), .rd_data_i(rd_data),
    .ee_addr_o(ee_addr), .ee_rd_o(ee_rd), .ee_rdata_i(ee_rdata), .ee_wr_o(ee_wr), .ee_wdata_o(ee_wdata),
    .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_ready_i(wr_ready));
  shpa_ee_model u_ee (.cs_n_i(cs_o), .sclk_i(sclk_o), .mosi_i(mosi_o), .miso_o(em_miso), .hdr_o(em_hdr));
  // register file and eeprom stand-ins, one cycle read latency
  always @(posedge mclk) begin
    if (rd_en) rd_data <= rd_addr[7:0] ^ 8'h5A;
    ee_rdata <= ee_mem[ee_addr[7:0]];
    if (ee_wr) ee_mem[ee_addr[7:0]] <= ee_wdata;
    n_rd <= n_rd + int'(ee_rd);
    n_wr <= n_wr + int'(ee_wr);
    if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xbyte(input logic [7:0] tx, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      // wired data line: master lets go while the device drives it
      mosi <= miso_oe ? miso : tx[i];
      sclk <= 1'b0;
      repeat (8) @(posedge mclk);
      r = {r[6:0], miso};
      sclk <= 1'b1;
      repeat (8) @(posedge mclk);
    end
  endtask : xbyte
  task automatic cs_up;
    sclk <= 1'b0;
    repeat (8) @(posedge mclk);
    cs <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask : cs_up
  task automatic hdr(input logic [7:0] cmd, input logic [15:0] a);
    cs <= 1'b0;
    repeat (8) @(posedge mclk);
    xbyte(cmd, 8);
    xbyte(a[15:8], 8);
    xbyte(a[7:0], 8);
  endtask : hdr
  task automatic solo(input logic [7:0] c, input int tail);
    cs <= 1'b0;
    repeat (8) @(posedge mclk);
    xbyte(c, 8);
    xbyte(8'h00, tail);
    cs_up;
  endtask : solo
  task automatic do_reset(input logic s);
    srst <= 1'b1;
    strap <= s;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : do_reset
  task automatic t_reg_write;
    hdr(8'h02, 16'h1234);
    xbyte(8'hA5, 8);
    xbyte(8'h3C, 8);
    xbyte(8'hF0, 4);
    cs_up;
    chk(wq.size(), 2);
    chk(wq[0], 24'h1234A5);
    chk(wq[1], 24'h12353C);
    wq.delete();
  endtask : t_reg_write
  task automatic t_buf_stall;
    wr_ready <= 1'b0;
    hdr(8'h02, 16'h0010);
    xbyte(8'h11, 8);
    xbyte(8'h22, 8);
    xbyte(8'h33, 8);
    cs_up;
    chk(wq.size(), 0);
    wr_ready <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(wq.size(), 2);
    chk(wq[0], 24'h001011);
    chk(wq[1], 24'h001122);
    wq.delete();
  endtask : t_buf_stall
  task automatic t_read;
    hdr(8'h03, 16'h00FE);
    xbyte(8'h00, 8);
    chk(r, 8'hA4);
    chk(miso_oe, 1);
    xbyte(8'h00, 8);
    chk(r, 8'hA5);
    chk(pins_oe, 0);
    cs_up;
    chk(miso_oe, 0);
  endtask : t_read
  task automatic t_idle_abort;
    xbyte(8'hC3, 8);
    cs_up;
    hdr(8'h9C, 16'h0001);
    xbyte(8'h55, 8);
    chk(miso_oe, 0);
    cs_up;
    cs <= 1'b0;
    repeat (8) @(posedge mclk);
    xbyte(8'h02, 5);
    cs_up;
    hdr(8'h02, 16'h0002);
    xbyte(8'h77, 8);
    cs_up;
    chk(wq.size(), 1);
    chk(wq[0], 24'h000277);
    wq.delete();
  endtask : t_idle_abort
  task automatic t_eeprom;
    int b0;
    mts <= 1'b1;
    hdr(8'h02, 16'h005E);
    xbyte(8'h11, 8);
    cs_up;
    solo(8'h06, 0);
    hdr(8'h02, 16'h005E);
    xbyte(8'h11, 8);
    xbyte(8'h22, 3);
    cs_up;
    repeat (80) @(posedge mclk);
    chk(n_wr, 0);
    solo(8'h06, 0);
    b0 = n_rd;
    hdr(8'h02, 16'h005E);
    xbyte(8'h11, 8);
    xbyte(8'h22, 8);
    xbyte(8'h33, 8);
    cs_up;
    solo(8'h05, 8);
    chk(r[0], 1);
    repeat (PC + 100) @(posedge mclk);
    chk(n_rd - b0, 32);
    chk(n_wr, 32);
    chk({ee_mem[8'h5F], ee_mem[8'h40], ee_mem[8'h41]}, 24'h223341);
    solo(8'h05, 8);
    chk(r[0], 0);
    hdr(8'h03, 16'h005E);
    xbyte(8'h00, 8);
    cs_up;
    chk(r, 8'h11);
    mts <= 1'b0;
  endtask : t_eeprom
  task automatic t_master;
    do_reset(1'b1);
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(posedge mclk);
    chk(done, 1);
    chk(pins_oe, 1);
    chk(em_hdr, 24'h030000);
    chk(cs_o, 1);
    chk(wq.size(), 2);
    chk(wq[0], 24'h0000C3);
    chk(wq[1], 24'h0001C2);
  endtask : t_master
  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    for (int i = 0; i < 256; i++) ee_mem[i] = 8'(i);
    do_reset(1'b0);
    t_reg_write;
    t_buf_stall;
    t_read;
    t_idle_abort;
    t_eeprom;
    t_master;
    tally_and_finish;
  end
  // about ten times the expected run
  initial begin
    #1000000;
    errors++;
    tally_and_finish;
  end
endmodule : tb_shpa_top
